// ### pkg/sdtx_pkg.sv
// constants and types for the serial audio input deformatter
// How it works
// R1: accepts left-justified, I2S, right-justified; 16/18/20/24 bits
// R2: data and channel clock sampled on bit-clock rise
// R3: right-justified: high channel clock means left sample
// R4: I2S is default; low channel clock means left
// R5: I2S MSB one bit clock after transition
// R6: left-justified: high is left, MSB immediately
// R7: right-justified MSB at 32 minus width
package sdtx_pkg;
    typedef enum logic [1:0] {
        SDTX_FMT_I2S   = 2'b00,
        SDTX_FMT_LEFT  = 2'b01,
        SDTX_FMT_RIGHT = 2'b10
    } sdtx_fmt_t;

    typedef enum logic [1:0] {
        SDTX_W16 = 2'b00,
        SDTX_W18 = 2'b01,
        SDTX_W20 = 2'b10,
        SDTX_W24 = 2'b11
    } sdtx_width_t;

    localparam int unsigned SDTX_SAMPLE_BITS = 24;
    localparam int unsigned SDTX_SLOT_BITS   = 32;
    localparam int unsigned SDTX_CNT_BITS    = 6;
    localparam int unsigned SDTX_SYNC_STAGES = 3;
    localparam sdtx_fmt_t   SDTX_FMT_RESET   = SDTX_FMT_I2S;

    typedef struct packed {
        logic                        right_ch;
        logic [SDTX_SAMPLE_BITS-1:0] sample;
    } sdtx_word_t;

    localparam int unsigned SDTX_WORD_BITS = $bits(sdtx_word_t);

    function automatic logic [5:0] sdtx_width_bits(input sdtx_width_t w);
        unique case (w)
            SDTX_W16: sdtx_width_bits = 6'h10;
            SDTX_W18: sdtx_width_bits = 6'h12;
            SDTX_W20: sdtx_width_bits = 6'h14;
            SDTX_W24: sdtx_width_bits = 6'h18;
        endcase
    endfunction
endpackage

// ### design/sdtx_sync.sv
// three-stage synchroniser with agreement of the last two stages
module sdtx_sync
    import sdtx_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [SDTX_SYNC_STAGES-1:0] stage_reg;
    logic [SDTX_SYNC_STAGES-1:0] stage_next;
    logic                        out_reg;
    logic                        out_next;

    always_comb begin
        stage_next = stage_reg;
        out_next   = out_reg;
        if (clk_en) begin
            stage_next = {stage_reg[SDTX_SYNC_STAGES-2:0], async_in};
            if (stage_reg[1] == stage_reg[2]) begin
                out_next = stage_reg[2];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            stage_reg <= '0;
            out_reg   <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            out_reg   <= out_next;
        end
    end

    assign sync_out = out_reg;
endmodule // sdtx_sync

// ### design/sdtx_fifo.sv
// synchronous valid/ready fifo for captured samples
module sdtx_fifo #(
    parameter int unsigned WIDTH = 25,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];
    assign push      = clk_en && in_valid && in_ready;
    assign pop       = clk_en && out_valid && out_ready;

    always_comb begin
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        cnt_next = cnt_reg;
        if (push) begin
            wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
        end
        if (pop) begin
            rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule // sdtx_fifo

// ### design/sdtx_deformatter.sv
// serial audio input deformatter: extracts left/right samples into a fifo
module sdtx_deformatter
    import sdtx_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 32
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst_b,
    input  wire logic                        clk_en,
    input  wire logic                        bit_clk,
    input  wire logic                        chan_clk,
    input  wire logic                        ser_data,
    input  wire sdtx_fmt_t                   fmt_sel,
    input  wire sdtx_width_t                 width_sel,
    output logic                             smp_valid,
    input  wire logic                        smp_ready,
    output logic                             smp_right,
    output logic      [SDTX_SAMPLE_BITS-1:0] smp_data,
    output logic                             overflow
);
    logic bclk_s;
    logic lrck_s;
    logic data_s;

    sdtx_sync u_sync_bclk (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .async_in (bit_clk),
        .sync_out (bclk_s)
    );

    sdtx_sync u_sync_lrck (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .async_in (chan_clk),
        .sync_out (lrck_s)
    );

    sdtx_sync u_sync_data (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .async_in (ser_data),
        .sync_out (data_s)
    );

    // capture state
    logic                        bclk_d_reg;
    logic                        bclk_d_next;
    logic                        lrck_reg;
    logic                        lrck_next;
    logic [SDTX_CNT_BITS-1:0]    bitcnt_reg;
    logic [SDTX_CNT_BITS-1:0]    bitcnt_next;
    logic [SDTX_SAMPLE_BITS-1:0] shift_reg;
    logic [SDTX_SAMPLE_BITS-1:0] shift_next;
    logic                        right_reg;
    logic                        right_next;
    logic                        done_reg;
    logic                        done_next;
    logic                        push_reg;
    logic                        push_next;
    sdtx_word_t                  word_reg;
    sdtx_word_t                  word_next;
    logic                        ovf_reg;
    logic                        ovf_next;
    sdtx_fmt_t                   fmt_reg;
    sdtx_fmt_t                   fmt_next;
    sdtx_width_t                 wid_reg;
    sdtx_width_t                 wid_next;

    logic                        fifo_in_ready;
    sdtx_word_t                  fifo_out;

    logic                        rise;
    logic                        lr_edge;
    logic [SDTX_CNT_BITS-1:0]    nbits;
    logic [SDTX_CNT_BITS-1:0]    first_pos;
    logic [SDTX_CNT_BITS-1:0]    pos;
    logic                        in_word;
    sdtx_fmt_t                   fmt_cur;
    sdtx_width_t                 wid_cur;
    logic                        right_cur;
    logic [SDTX_SAMPLE_BITS-1:0] shift_base;

    assign rise    = bclk_s && !bclk_d_reg;       // see R2
    assign lr_edge = (lrck_s != lrck_reg);

    // a half frame runs with the settings taken at its own channel clock edge
    always_comb begin
        fmt_cur = fmt_reg;
        wid_cur = wid_reg;
        if (rise && lr_edge) begin
            fmt_cur = fmt_sel;
            wid_cur = width_sel;
        end
    end

    assign nbits   = sdtx_width_bits(wid_cur);    // see R1
    // left is low in I2S and the spare code, high in the justified formats
    assign right_cur = (fmt_cur == SDTX_FMT_LEFT || fmt_cur == SDTX_FMT_RIGHT)
        ? !lrck_s : lrck_s; // see R3 R4 R6
    assign shift_base = lr_edge ? '0 : shift_reg;
    // bit position of this rise within the half frame
    assign pos     = lr_edge ? '0 : bitcnt_reg;

    always_comb begin
        unique case (fmt_cur)
            SDTX_FMT_I2S:   first_pos = SDTX_CNT_BITS'(1);                     // see R5
            SDTX_FMT_LEFT:  first_pos = '0;                                    // see R6
            SDTX_FMT_RIGHT: first_pos = SDTX_CNT_BITS'(SDTX_SLOT_BITS) - nbits; // see R3 R7
            default:        first_pos = SDTX_CNT_BITS'(1);
        endcase
    end

    assign in_word = (pos >= first_pos) && (pos < first_pos + nbits);

    always_comb begin
        bclk_d_next = bclk_d_reg;
        lrck_next   = lrck_reg;
        bitcnt_next = bitcnt_reg;
        shift_next  = shift_reg;
        right_next  = right_reg;
        done_next   = done_reg;
        push_next   = push_reg;
        word_next   = word_reg;
        ovf_next    = ovf_reg;
        fmt_next    = fmt_reg;
        wid_next    = wid_reg;
        if (clk_en) begin
            bclk_d_next = bclk_s;
            push_next   = 1'b0;
            // the word offered to a full fifo is the one that is dropped
            if (push_reg && !fifo_in_ready) begin
                ovf_next = 1'b1;
            end
            if (rise) begin
                lrck_next = lrck_s;
                if (lr_edge) begin
                    // settings change only at half-frame boundaries
                    fmt_next   = fmt_cur;
                    wid_next   = wid_cur;
                    shift_next = '0;
                    done_next  = 1'b0;
                    right_next = right_cur; // see R4 R3 R6
                end
                if (pos != '1) begin
                    bitcnt_next = pos + 1'b1;
                end else begin
                    bitcnt_next = pos;
                end
                if (in_word && !(done_reg && !lr_edge)) begin
                    shift_next = {shift_base[SDTX_SAMPLE_BITS-2:0], data_s};
                    if (pos == first_pos + nbits - 1'b1) begin
                        done_next          = 1'b1;
                        push_next          = 1'b1;
                        word_next.right_ch = lr_edge ? right_cur : right_reg;
                        word_next.sample   = {shift_base[SDTX_SAMPLE_BITS-2:0], data_s};
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bclk_d_reg <= 1'b0;
            lrck_reg   <= 1'b0;
            bitcnt_reg <= '0;
            shift_reg  <= '0;
            right_reg  <= 1'b0;
            done_reg   <= 1'b0;
            push_reg   <= 1'b0;
            word_reg   <= '0;
            ovf_reg    <= 1'b0;
            fmt_reg    <= SDTX_FMT_RESET; // see R4
            wid_reg    <= SDTX_W24;
        end else begin
            bclk_d_reg <= bclk_d_next;
            lrck_reg   <= lrck_next;
            bitcnt_reg <= bitcnt_next;
            shift_reg  <= shift_next;
            right_reg  <= right_next;
            done_reg   <= done_next;
            push_reg   <= push_next;
            word_reg   <= word_next;
            ovf_reg    <= ovf_next;
            fmt_reg    <= fmt_next;
            wid_reg    <= wid_next;
        end
    end

    sdtx_fifo #(
        .WIDTH (SDTX_WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .in_valid  (push_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (word_reg),
        .out_valid (smp_valid),
        .out_ready (smp_ready),
        .out_data  (fifo_out)
    );

    assign smp_right = fifo_out.right_ch;
    assign smp_data  = fifo_out.sample;
    assign overflow  = ovf_reg;
endmodule // sdtx_deformatter

// ### dv/sdtx_deformatter_properties.sv
// port assertions and covers for the serial audio deformatter
module sdtx_deformatter_properties
    import sdtx_pkg::*;
(
    input wire logic                        sys_clk,
    input wire logic                        rst_b,
    input wire logic                        clk_en,
    input wire logic                        bit_clk,
    input wire logic                        smp_valid,
    input wire logic                        smp_ready,
    input wire logic                        smp_right,
    input wire logic [SDTX_SAMPLE_BITS-1:0] smp_data,
    input wire logic                        overflow
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_rst_clear;
        $rose(rst_b) |-> !smp_valid && !overflow;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("outputs not clear after reset");
    property p_sticky;
        overflow |=> overflow;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("overflow flag dropped");
    property p_hold;
        smp_valid && !smp_ready |=> smp_valid && $stable(smp_data) && $stable(smp_right);
    endproperty
    a_hold: assert property (p_hold)
        else $error("head sample changed while not taken");
    property p_freeze;
        !clk_en |=> $stable(smp_valid) && $stable(overflow);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with clock enable low");
    property p_pop;
        $fell(smp_valid) && $past(rst_b) |-> $past(smp_ready && clk_en);
    endproperty
    a_pop: assert property (p_pop)
        else $error("valid fell without a pop");
    property p_ovf_cause;
        $rose(overflow) |-> $past(smp_valid && clk_en);
    endproperty
    a_ovf_cause: assert property (p_ovf_cause)
        else $error("overflow set with empty fifo");
    property p_ovf_full;
        $rose(overflow) |-> $past(smp_valid, 200);
    endproperty
    a_ovf_full: assert property (p_ovf_full)
        else $error("overflow set before fifo could fill");
    // samples come only from captured bit-clock rises
    property p_idle;
        (clk_en && $stable(bit_clk)) [*8] |=> !$rose(smp_valid);
    endproperty
    a_idle: assert property (p_idle)
        else $error("sample appeared with bit clock idle");

    c_pop: cover property (smp_valid && smp_ready && clk_en);
    c_right: cover property (smp_valid && smp_right);
    c_ovf: cover property ($rose(overflow));
endmodule // sdtx_deformatter_properties

bind sdtx_deformatter sdtx_deformatter_properties u_sdtx_deformatter_properties (
    .sys_clk, .rst_b, .clk_en, .bit_clk, .smp_valid, .smp_ready, .smp_right, .smp_data,
    .overflow
);

// ### dv/sdtx_audio_src.sv
// behavioural serial audio source: bit clock, channel clock and data
module sdtx_audio_src
    import sdtx_pkg::*;
(
    output logic bit_clk,
    output logic chan_clk,
    output logic ser_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        bit_clk = 1'b0;
        chan_clk = 1'b0;
        ser_data = 1'b0;
    end
    // one half-frame of 32 bit clocks; data outside the word toggles
    task automatic send_half(input int first, input int n, input logic [23:0] w, input int hp);
        for (int p = 0; p < 32; p++) begin
            if (p == 0) chan_clk = ~chan_clk;
            if (p >= first && p < first + n) ser_data = w[n - 1 - (p - first)];
            else ser_data = ~ser_data;
            #hp bit_clk = 1'b1;
            #hp bit_clk = 1'b0;
        end
    endtask
    // bit clock stands low between frames
    task automatic send_frame(input sdtx_fmt_t f, input sdtx_width_t w, input logic [23:0] l,
                              input logic [23:0] r, input int hp);
        int   n;
        int   first;
        logic lv;
        n = (w == SDTX_W24) ? 24 : 16 + 2 * int'(w);
        first = (f == SDTX_FMT_LEFT) ? 0 : (f == SDTX_FMT_RIGHT) ? 32 - n : 1;
        lv = (f != SDTX_FMT_I2S);
        #5;
        repeat (2) send_half(first, n, ((~chan_clk) == lv) ? l : r, hp);
    endtask
endmodule // sdtx_audio_src

// ### dv/sdtx_deformatter_tb.sv
// self-checking bench for the serial audio deformatter
module sdtx_deformatter_tb
    import sdtx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                        sys_clk = 1'b0;
    logic                        rst_b, clk_en, smp_ready;
    logic                        bit_clk, chan_clk, ser_data;
    sdtx_fmt_t                   fmt_sel;
    sdtx_width_t                 width_sel;
    logic                        smp_valid, smp_right, overflow;
    logic [SDTX_SAMPLE_BITS-1:0] smp_data;
    int                          n_mismatch = 0;
    int                          check_count = 0;
    int                          cyc = 0;

    always #4 sys_clk = ~sys_clk;
    sdtx_deformatter #(.FIFO_DEPTH(32)) u_sdtx_deformatter (.sys_clk, .rst_b, .clk_en, .bit_clk,
        .chan_clk, .ser_data, .fmt_sel, .width_sel, .smp_valid, .smp_ready, .smp_right,
        .smp_data, .overflow);
    sdtx_audio_src u_sdtx_audio_src (.bit_clk, .chan_clk, .ser_data);

    task automatic check(input logic [25:0] seen, input logic [25:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            results();
        end
    end
    // waits for the head word, compares it, then takes it
    task automatic pop(input logic [24:0] exp);
        int k;
        k = 0;
        @(negedge sys_clk);
        while (smp_valid !== 1'b1 && k < 2000) begin
            @(negedge sys_clk);
            k++;
        end
        check({smp_valid, smp_right, smp_data}, {1'b1, exp});
        smp_ready = 1'b1;
        @(negedge sys_clk);
        smp_ready = 1'b0;
    endtask
    task automatic t_warm();
        u_sdtx_audio_src.send_frame(SDTX_FMT_I2S, SDTX_W24, 24'h0, 24'h0, 32);
        @(negedge sys_clk);
        smp_ready = 1'b1;
        repeat (60) @(negedge sys_clk);
        smp_ready = 1'b0;
    endtask
    task automatic t_formats();
        logic [23:0] m;
        logic [23:0] l;
        logic [23:0] r;
        logic        fr;
        for (int f = 0; f < 3; f++) begin
            for (int w = 0; w < 4; w++) begin
                fmt_sel = sdtx_fmt_t'(f);
                width_sel = sdtx_width_t'(w);
                m = 24'hFFFFFF >> ((w == 3) ? 0 : 8 - 2 * w);
                l = 24'hC3A5E7 & m;
                r = 24'h5A3C96 & m;
                fr = (~chan_clk) != (f != 0);
                u_sdtx_audio_src.send_frame(fmt_sel, width_sel, l, r, 32);
                pop(fr ? {1'b1, r} : {1'b0, l});
                pop(fr ? {1'b0, l} : {1'b1, r});
            end
        end
    endtask
    function automatic logic [24:0] ovf_word(input int i, input logic fr);
        logic rt;
        rt = ((i % 2) == 0) == fr;
        return rt ? {1'b1, 16'h5A5A, 8'(i / 2)} : {1'b0, 16'hA5A5, 8'(i / 2)};
    endfunction
    // consumer stalled: fill, freeze, then drain the 32 kept words
    task automatic t_overflow();
        logic fr;
        fmt_sel = SDTX_FMT_LEFT;
        width_sel = SDTX_W24;
        fr = chan_clk;
        for (int k = 0; k < 17; k++)
            u_sdtx_audio_src.send_frame(fmt_sel, width_sel, {16'hA5A5, 8'(k)},
                                        {16'h5A5A, 8'(k)}, 32);
        repeat (10) @(negedge sys_clk);
        check({25'h0, overflow}, 26'h1);
        clk_en = 1'b0;
        smp_ready = 1'b1;
        repeat (3) @(negedge sys_clk);
        check({smp_valid, smp_right, smp_data}, {1'b1, ovf_word(0, fr)});
        smp_ready = 1'b0;
        clk_en = 1'b1;
        for (int i = 0; i < 32; i++) pop(ovf_word(i, fr));
        repeat (3) @(negedge sys_clk);
        check({24'h0, smp_valid, overflow}, 26'h1);
    endtask
    // mid-run reset, then one frame with the spare format code, which runs as I2S
    task automatic t_reset();
        rst_b = 1'b0;
        repeat (4) @(negedge sys_clk);
        rst_b = 1'b1;
        check({24'h0, smp_valid, overflow}, 26'h0);
        fmt_sel = sdtx_fmt_t'(2'b11);
        width_sel = SDTX_W16;
        u_sdtx_audio_src.send_frame(SDTX_FMT_I2S, SDTX_W16, 24'h00C3A5, 24'h005A3C, 32);
        pop({1'b1, 24'h005A3C});
        pop({1'b0, 24'h00C3A5});
    endtask

    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        smp_ready = 1'b0;
        fmt_sel = SDTX_FMT_I2S;
        width_sel = SDTX_W24;
        repeat (4) @(negedge sys_clk);
        rst_b = 1'b1;
        t_warm();
        t_formats();
        t_overflow();
        t_reset();
        results();
    end
endmodule // sdtx_deformatter_tb
